// >>> include/irq_wake_pkg.sv
// shared constants and types for the interrupt and wake-up control block
package irq_wake_pkg;
    localparam int unsigned NUM_IRQ = 32;
    localparam int unsigned PRIO_W = 2;
    localparam int unsigned NUM_LEVELS = 4;
    localparam int unsigned ID_W = 5;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned LATENCY_MAX_CYC = 15;
    // wake source vector layout
    localparam int unsigned WS_RESET_PIN = 0;
    localparam int unsigned WS_WATCHDOG_RESET_SRC = 1;
    localparam int unsigned WS_DEBUG = 2;
    localparam int unsigned WS_PIN_IRQ = 3;
    localparam int unsigned WS_ADC = 4;
    localparam int unsigned WS_CMP = 5;
    localparam int unsigned WS_SERIAL = 6;
    localparam int unsigned WS_TPM = 7;
    localparam int unsigned WS_PIO = 8;
    localparam int unsigned WS_LOWPOWER_TIMER = 9;
    localparam int unsigned NUM_WS = 10;
    localparam logic [NUM_IRQ-1:0] PEND_RESET = 32'h0000_0000;
    localparam logic [PRIO_W-1:0] PRIO_IDLE = 2'h3;

    typedef enum logic [2:0] {
        PM_RUN,
        PM_WAIT,
        PM_VLP_WAIT,
        PM_STOP,
        PM_VLP_STOP,
        PM_LL_STOP,
        PM_VLL_STOP
    } power_mode_e;
endpackage

// >>> src/async_wake_ctrl.sv
// clock-free wake detection with clock restart handshake
`timescale 1ns/1ps
module async_wake_ctrl (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic stop_mode_i,
    input wire logic [irq_wake_pkg::NUM_WS-1:0] wake_src_i,
    input wire logic clk_stable_i,
    output logic restart_req_o,
    output logic wake_seen_o
);
    // latch is asynchronous: clocks are stopped while armed
    logic wake_latch;
    logic wake_any;
    logic clr_pulse_reg;
    logic clr_pulse_next;
    logic stable_s1_reg;
    logic stable_s2_reg;
    logic seen_reg;
    logic seen_next;

    assign wake_any = stop_mode_i && (|wake_src_i);

    always_latch
    begin
        // a fresh event in the clear cycle wins, so no wake is lost
        if (!resetn_i)
        begin
            wake_latch = 1'b0;
        end
        else if (wake_any)
        begin
            wake_latch = 1'b1;
        end
        else if (clr_pulse_reg)
        begin
            wake_latch = 1'b0;
        end
    end

    always_comb
    begin
        clr_pulse_next = wake_latch && stable_s2_reg && !clr_pulse_reg;
        seen_next = clr_pulse_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            stable_s1_reg <= 1'b0;
            stable_s2_reg <= 1'b0;
            clr_pulse_reg <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            stable_s1_reg <= clk_stable_i;
            stable_s2_reg <= stable_s1_reg;
            clr_pulse_reg <= clr_pulse_next;
            seen_reg <= seen_next;
        end
    end

    assign restart_req_o = wake_latch;
    assign wake_seen_o = seen_reg;
endmodule

// >>> src/irq_wake_ctrl.sv
// nested priority interrupt controller with stop-mode wake handling
`timescale 1ns/1ps
// Contract
// - nesting: higher priority preempts lower; exactly four levels
// - each source has a two-bit priority field
// - thirty-two vectors, each with request, pending and priority
// - request to handler start within fifteen clocks
// - enabled interrupt wakes core from wait and very-low-power wait
// - stopped clocks: detect async wake, request clock restart
// - after restart, waking interrupt is pending and handled normally
// - async wake works from stop and very-low-power stop
// - reset pin, watchdog on low-power osc, debug reset wake
// - any enabled pin interrupt wakes from stop modes
// - converter wakes only on its internal clock
// - comparator wakes only in periodic trigger mode
// - serial, timer, programmable io wake only on stop-active clock
// - low-power timer wakes if its clock stays active
// - stop: controller disabled, wake only through async path
// - very-low-power stop: controller and voltage detector disabled
module irq_wake_ctrl (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [irq_wake_pkg::NUM_IRQ-1:0] irq_req_i,
    input wire logic [irq_wake_pkg::NUM_IRQ-1:0] irq_enable_i,
    input wire logic [irq_wake_pkg::NUM_IRQ*irq_wake_pkg::PRIO_W-1:0] irq_prio_i,
    input wire logic irq_ack_i,
    input wire logic irq_done_i,
    input wire logic [2:0] power_mode_i,
    input wire logic reset_pin_evt_i,
    input wire logic watchdog_reset_src_evt_i,
    input wire logic watchdog_reset_src_on_lpo_i,
    input wire logic debug_reset_evt_i,
    input wire logic pin_irq_evt_i,
    input wire logic pin_irq_en_i,
    input wire logic adc_evt_i,
    input wire logic adc_int_clk_i,
    input wire logic cmp_evt_i,
    input wire logic cmp_trigger_mode_i,
    input wire logic serial_evt_i,
    input wire logic serial_clk_on_i,
    input wire logic tpm_evt_i,
    input wire logic tpm_clk_on_i,
    input wire logic pio_evt_i,
    input wire logic pio_clk_on_i,
    input wire logic lowpower_timer_evt_i,
    input wire logic lowpower_timer_clk_on_i,
    input wire logic clk_stable_i,
    output logic irq_valid_o,
    output logic [irq_wake_pkg::ID_W-1:0] irq_id_o,
    output logic [irq_wake_pkg::PRIO_W-1:0] irq_level_o,
    output logic core_wake_o,
    output logic restart_req_o,
    output logic lvd_enable_o,
    output logic [irq_wake_pkg::NUM_IRQ-1:0] pending_o
);
    ////////////////////////////////////////////////////////////////////////
    // prio extraction used by arbitration and preemption
    function automatic logic [irq_wake_pkg::PRIO_W-1:0] prio_of(
        input logic [irq_wake_pkg::NUM_IRQ*irq_wake_pkg::PRIO_W-1:0] p,
        input logic [irq_wake_pkg::ID_W-1:0] id
    );
        prio_of = p[id*irq_wake_pkg::PRIO_W +: irq_wake_pkg::PRIO_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [irq_wake_pkg::NUM_IRQ-1:0] req_s1_reg;
    logic [irq_wake_pkg::NUM_IRQ-1:0] req_s2_reg;
    logic [irq_wake_pkg::NUM_WS-1:0] wake_src;
    logic [2:0] mode_s1_reg;
    logic [2:0] mode_s2_reg;

    ////////////////////////////////////////////////////////////////////////
    // qualified wake sources, gated by enable, mode or clock conditions; reset pin and debug ungated
    always_comb
    begin
        wake_src = '0;
        wake_src[irq_wake_pkg::WS_RESET_PIN] = reset_pin_evt_i;
        wake_src[irq_wake_pkg::WS_WATCHDOG_RESET_SRC] = watchdog_reset_src_evt_i && watchdog_reset_src_on_lpo_i;
        wake_src[irq_wake_pkg::WS_DEBUG] = debug_reset_evt_i;
        wake_src[irq_wake_pkg::WS_PIN_IRQ] = pin_irq_evt_i && pin_irq_en_i;
        wake_src[irq_wake_pkg::WS_ADC] = adc_evt_i && adc_int_clk_i;
        wake_src[irq_wake_pkg::WS_CMP] = cmp_evt_i && cmp_trigger_mode_i;
        wake_src[irq_wake_pkg::WS_SERIAL] = serial_evt_i && serial_clk_on_i;
        wake_src[irq_wake_pkg::WS_TPM] = tpm_evt_i && tpm_clk_on_i;
        wake_src[irq_wake_pkg::WS_PIO] = pio_evt_i && pio_clk_on_i;
        wake_src[irq_wake_pkg::WS_LOWPOWER_TIMER] = lowpower_timer_evt_i && lowpower_timer_clk_on_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // async wake controller; stop mode decoded from raw pins, no clock there
    logic stop_raw;
    logic restart_req;
    logic wake_seen;

    assign stop_raw = (power_mode_i == 3'(irq_wake_pkg::PM_STOP))
                   || (power_mode_i == 3'(irq_wake_pkg::PM_VLP_STOP));

    async_wake_ctrl u_awake (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .stop_mode_i(stop_raw),
        .wake_src_i(wake_src),
        .clk_stable_i(clk_stable_i),
        .restart_req_o(restart_req),
        .wake_seen_o(wake_seen)
    );

    ////////////////////////////////////////////////////////////////////////
    // controller state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OFFER,
        ST_ACTIVE
    } ctl_state_e;

    localparam int unsigned DEPTH = irq_wake_pkg::NUM_LEVELS;

    ctl_state_e state_reg;
    ctl_state_e state_next;
    logic [irq_wake_pkg::NUM_IRQ-1:0] pend_reg;
    logic [irq_wake_pkg::NUM_IRQ-1:0] pend_next;
    logic [irq_wake_pkg::NUM_IRQ-1:0] req_prev_reg;
    logic [irq_wake_pkg::PRIO_W-1:0] cur_prio_reg;
    logic [irq_wake_pkg::PRIO_W-1:0] cur_prio_next;
    logic cur_act_reg;
    logic cur_act_next;
    // stack of preempted priorities, one slot per level
    logic [irq_wake_pkg::PRIO_W-1:0] stk_reg [DEPTH];
    logic [irq_wake_pkg::PRIO_W-1:0] stk_next [DEPTH];
    logic [2:0] sp_reg;
    logic [2:0] sp_next;
    logic valid_reg;
    logic valid_next;
    logic [irq_wake_pkg::ID_W-1:0] id_reg;
    logic [irq_wake_pkg::ID_W-1:0] id_next;
    logic [irq_wake_pkg::PRIO_W-1:0] lvl_reg;
    logic [irq_wake_pkg::PRIO_W-1:0] lvl_next;
    logic wake_reg;
    logic wake_next;
    logic rr_reg;
    logic lvd_reg;
    logic lvd_next;

    logic ctl_on;
    logic in_wait;
    logic best_found;
    logic [irq_wake_pkg::ID_W-1:0] best_id;
    logic [irq_wake_pkg::PRIO_W-1:0] best_prio;
    logic [irq_wake_pkg::NUM_IRQ-1:0] req_rise;

    always_comb
    begin
        ctl_on = !((mode_s2_reg == 3'(irq_wake_pkg::PM_STOP))
                || (mode_s2_reg == 3'(irq_wake_pkg::PM_VLP_STOP)));
        in_wait = (mode_s2_reg == 3'(irq_wake_pkg::PM_WAIT))
               || (mode_s2_reg == 3'(irq_wake_pkg::PM_VLP_WAIT));
        req_rise = req_s2_reg & ~req_prev_reg;
    end

    // lowest numeric priority wins, lower id breaks ties
    always_comb
    begin
        best_found = 1'b0;
        best_id = '0;
        best_prio = irq_wake_pkg::PRIO_IDLE;
        for (int i = irq_wake_pkg::NUM_IRQ - 1; i >= 0; i--)
        begin
            if (pend_reg[i] && irq_enable_i[i]
                && (!best_found || prio_of(irq_prio_i, 5'(i)) <= best_prio))
            begin
                best_found = 1'b1;
                best_id = 5'(i);
                best_prio = prio_of(irq_prio_i, 5'(i));
            end
        end
    end

    always_comb
    begin
        state_next = state_reg;
        pend_next = pend_reg | req_rise;
        cur_prio_next = cur_prio_reg;
        cur_act_next = cur_act_reg;
        stk_next = stk_reg;
        sp_next = sp_reg;
        valid_next = 1'b0;
        id_next = id_reg;
        lvl_next = lvl_reg;
        wake_next = 1'b0;
        lvd_next = (mode_s2_reg != 3'(irq_wake_pkg::PM_VLP_STOP))
                && (mode_s2_reg != 3'(irq_wake_pkg::PM_VLP_WAIT));
        case (state_reg)
            ST_IDLE:
            begin
                // preempt only with strictly higher priority
                if (ctl_on && best_found
                    && (!cur_act_reg || best_prio < cur_prio_reg))
                begin
                    state_next = ST_OFFER;
                    valid_next = 1'b1;
                    id_next = best_id;
                    lvl_next = best_prio;
                    wake_next = in_wait;
                end
                else if (irq_done_i && cur_act_reg)
                begin
                    if (sp_reg != 3'h0)
                    begin
                        sp_next = sp_reg - 3'h1;
                        cur_prio_next = stk_reg[2'(sp_reg - 3'h1)];
                    end
                    else
                    begin
                        cur_act_next = 1'b0;
                    end
                end
            end
            ST_OFFER:
            begin
                valid_next = 1'b1;
                if (irq_ack_i)
                begin
                    valid_next = 1'b0;
                    pend_next[id_reg] = req_rise[id_reg]; // new edge wins over clear
                    if (cur_act_reg && sp_reg < 3'(DEPTH))
                    begin
                        stk_next[2'(sp_reg)] = cur_prio_reg;
                        sp_next = sp_reg + 3'h1;
                    end
                    cur_prio_next = lvl_reg;
                    cur_act_next = 1'b1;
                    state_next = ST_ACTIVE;
                end
                else if (!ctl_on)
                begin
                    valid_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_ACTIVE:
            begin
                state_next = ST_IDLE; // one-cycle settle before next offer
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            req_s1_reg <= '0;
            req_s2_reg <= '0;
            req_prev_reg <= '0;
            mode_s1_reg <= 3'h0;
            mode_s2_reg <= 3'h0;
            state_reg <= ST_IDLE;
            pend_reg <= irq_wake_pkg::PEND_RESET;
            cur_prio_reg <= irq_wake_pkg::PRIO_IDLE;
            cur_act_reg <= 1'b0;
            for (int i = 0; i < DEPTH; i++)
            begin
                stk_reg[i] <= irq_wake_pkg::PRIO_IDLE;
            end
            sp_reg <= 3'h0;
            valid_reg <= 1'b0;
            id_reg <= '0;
            lvl_reg <= '0;
            wake_reg <= 1'b0;
            rr_reg <= 1'b0;
            lvd_reg <= 1'b1;
        end
        else
        begin
            req_s1_reg <= irq_req_i;
            req_s2_reg <= req_s1_reg;
            req_prev_reg <= req_s2_reg;
            mode_s1_reg <= power_mode_i;
            mode_s2_reg <= mode_s1_reg;
            state_reg <= state_next;
            pend_reg <= pend_next;
            cur_prio_reg <= cur_prio_next;
            cur_act_reg <= cur_act_next;
            stk_reg <= stk_next;
            sp_reg <= sp_next;
            valid_reg <= valid_next;
            id_reg <= id_next;
            lvl_reg <= lvl_next;
            wake_reg <= wake_next || wake_seen;
            rr_reg <= restart_req;
            lvd_reg <= lvd_next;
        end
    end

    assign irq_valid_o = valid_reg;
    assign irq_id_o = id_reg;
    assign irq_level_o = lvl_reg;
    assign core_wake_o = wake_reg;
    assign restart_req_o = rr_reg;
    assign lvd_enable_o = lvd_reg;
    assign pending_o = pend_reg;
endmodule

// >>> verif/core_clk_model.sv
// core and clock control stand-in: takes offers, answers restart requests
`timescale 1ns/1ps
module core_clk_model (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic valid_i,
    input wire logic restart_i,
    input wire logic [3:0] ack_dly_i,
    input wire logic [3:0] stb_dly_i,
    output logic ack_o,
    output logic stable_o
);
    logic [3:0] ack_cnt = 4'h0;
    logic [3:0] stb_cnt = 4'h0;
    always @(posedge clock_i)
    begin
        ack_o <= 1'b0;
        if (!resetn_i || !valid_i || ack_o)
            ack_cnt <= 4'h0;
        else if (ack_cnt == ack_dly_i)
            ack_o <= 1'b1;
        else
            ack_cnt <= ack_cnt + 4'h1;
        // stays high until the request is gone, then drops at once
        if (!resetn_i || !restart_i)
        begin
            stb_cnt <= 4'h0;
            stable_o <= 1'b0;
        end
        else if (stb_cnt == stb_dly_i)
            stable_o <= 1'b1;
        else
            stb_cnt <= stb_cnt + 4'h1;
    end
endmodule

// >>> verif/irq_wake_ctrl_assertions.sv
// concurrent checks on the interrupt and wake-up control ports
`timescale 1ns/1ps
module irq_wake_ctrl_assertions (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [irq_wake_pkg::NUM_IRQ*irq_wake_pkg::PRIO_W-1:0] irq_prio_i,
    input wire logic irq_ack_i,
    input wire logic [2:0] power_mode_i,
    input wire logic pin_irq_evt_i,
    input wire logic pin_irq_en_i,
    input wire logic clk_stable_i,
    input wire logic irq_valid_o,
    input wire logic [irq_wake_pkg::ID_W-1:0] irq_id_o,
    input wire logic [irq_wake_pkg::PRIO_W-1:0] irq_level_o,
    input wire logic core_wake_o,
    input wire logic restart_req_o,
    input wire logic lvd_enable_o,
    input wire logic [irq_wake_pkg::NUM_IRQ-1:0] pending_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // mode reaches the arbiter late, so holding is claimed only in run and wait modes
    property p_hold;
        irq_valid_o && !irq_ack_i && power_mode_i < 3'h3 && $past(power_mode_i) < 3'h3
            && $past(power_mode_i, 2) < 3'h3 |=> irq_valid_o && $stable(irq_id_o);
    endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");
    property p_ack;
        irq_valid_o && irq_ack_i |=> !irq_valid_o;
    endproperty
    a_ack: assert property (p_ack) else $error("offer kept after ack");
    property p_pend;
        irq_valid_o |-> pending_o[irq_id_o];
    endproperty
    a_pend: assert property (p_pend) else $error("offer without pending bit");
    property p_level;
        irq_valid_o |-> irq_level_o == irq_prio_i[irq_id_o*2 +: 2];
    endproperty
    a_level: assert property (p_level) else $error("offered level wrong");
    property p_stop;
        (power_mode_i == 3'h3) [*5] |-> !irq_valid_o;
    endproperty
    a_stop: assert property (p_stop) else $error("offer in stop");
    property p_very_low_power_stop;
        (power_mode_i == 3'h4) [*5] |-> !irq_valid_o && !lvd_enable_o;
    endproperty
    a_very_low_power_stop: assert property (p_very_low_power_stop) else $error("offer or detector in vlp stop");
    property p_lvd;
        (power_mode_i == 3'h0) [*5] |-> lvd_enable_o;
    endproperty
    a_lvd: assert property (p_lvd) else $error("detector off in run");
    property p_pin;
        $rose(pin_irq_evt_i) && pin_irq_en_i && power_mode_i == 3'h3 |-> ##[0:3] restart_req_o;
    endproperty
    a_pin: assert property (p_pin) else $error("pin event gave no restart");
    property p_req_hold;
        restart_req_o && !clk_stable_i |=> restart_req_o;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("restart dropped early");
    property p_req_rel;
        $rose(clk_stable_i) && restart_req_o |-> ##[1:8] !restart_req_o;
    endproperty
    a_req_rel: assert property (p_req_rel) else $error("restart not released");
    property p_core;
        $rose(restart_req_o) |-> ##[2:40] core_wake_o;
    endproperty
    a_core: assert property (p_core) else $error("core not woken");
    property p_pulse;
        core_wake_o |=> !core_wake_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake pulse too long");
endmodule
bind irq_wake_ctrl irq_wake_ctrl_assertions chk (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .irq_prio_i(irq_prio_i),
    .irq_ack_i(irq_ack_i),
    .power_mode_i(power_mode_i),
    .pin_irq_evt_i(pin_irq_evt_i),
    .pin_irq_en_i(pin_irq_en_i),
    .clk_stable_i(clk_stable_i),
    .irq_valid_o(irq_valid_o),
    .irq_id_o(irq_id_o),
    .irq_level_o(irq_level_o),
    .core_wake_o(core_wake_o),
    .restart_req_o(restart_req_o),
    .lvd_enable_o(lvd_enable_o),
    .pending_o(pending_o)
);

// >>> verif/irq_wake_ctrl_tb.sv
// self-checking bench for the interrupt and wake-up control block
`timescale 1ns/1ps
module irq_wake_ctrl_tb;
    logic clock_i, resetn_i, done, ack, stable, valid, wake, rreq, low_voltage_detector;
    logic [31:0] req, en, pend;
    logic [63:0] prio;
    logic [2:0] mode;
    logic [9:0] evt, qual;
    logic [3:0] ack_dly, stb_dly;
    logic [4:0] id;
    logic [1:0] lvl;
    logic [4:0] offers[$];
    int bad_count, num_checks;
    irq_wake_ctrl uut (.clock_i(clock_i), .resetn_i(resetn_i), .irq_req_i(req),
        .irq_enable_i(en), .irq_prio_i(prio), .irq_ack_i(ack), .irq_done_i(done),
        .power_mode_i(mode), .reset_pin_evt_i(evt[0]), .watchdog_reset_src_evt_i(evt[1]),
        .watchdog_reset_src_on_lpo_i(qual[1]), .debug_reset_evt_i(evt[2]), .pin_irq_evt_i(evt[3]),
        .pin_irq_en_i(qual[3]), .adc_evt_i(evt[4]), .adc_int_clk_i(qual[4]),
        .cmp_evt_i(evt[5]), .cmp_trigger_mode_i(qual[5]), .serial_evt_i(evt[6]),
        .serial_clk_on_i(qual[6]), .tpm_evt_i(evt[7]), .tpm_clk_on_i(qual[7]),
        .pio_evt_i(evt[8]), .pio_clk_on_i(qual[8]), .lowpower_timer_evt_i(evt[9]),
        .lowpower_timer_clk_on_i(qual[9]), .clk_stable_i(stable), .irq_valid_o(valid),
        .irq_id_o(id), .irq_level_o(lvl), .core_wake_o(wake), .restart_req_o(rreq),
        .lvd_enable_o(low_voltage_detector), .pending_o(pend));
    core_clk_model partner (.clock_i(clock_i), .resetn_i(resetn_i), .valid_i(valid),
        .restart_i(rreq), .ack_dly_i(ack_dly), .stb_dly_i(stb_dly), .ack_o(ack),
        .stable_o(stable));
    ////////////////////////////////////////////////////////////////
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function logic sig(input int w);
        return w == 0 ? valid : w == 1 ? wake : w == 2 ? rreq : !valid;
    endfunction
    // gives up after 40 cycles, so n == 40 means never seen
    task wait_sig(input int w, output int n);
        n = 0;
        while (sig(w) !== 1'b1 && n < 40)
        begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task fin(input logic d);
        @(posedge clock_i);
        {req, mode, qual, done} <= {32'h0, 3'h0, 10'h0, d};
        @(posedge clock_i);
        done <= 1'b0;
        repeat (6) @(negedge clock_i);
    endtask
    task automatic basic();
        int v[3] = '{0, 5, 31};
        int n;
        foreach (v[i])
        begin
            @(posedge clock_i);
            req[v[i]] <= 1'b1;
            wait_sig(0, n);
            chk(n <= irq_wake_pkg::LATENCY_MAX_CYC, "offer late");
            chk(id === v[i][4:0] && lvl === v[i][1:0], "offer id or level");
            wait_sig(3, n);
            chk(pend[v[i]] === 1'b0, "pending kept after ack");
            fin(1'b1);
        end
        @(posedge clock_i);
        {en[20], req[20]} <= 2'b01;
        wait_sig(0, n);
        chk(n == 40, "disabled vector offered");
        @(posedge clock_i);
        en[20] <= 1'b1;
        wait_sig(0, n);
        chk(id === 5'h14, "enabled vector not offered");
        wait_sig(3, n);
        fin(1'b1);
    endtask
    task pop();
        @(posedge clock_i);
        done <= 1'b1;
        @(posedge clock_i);
        done <= 1'b0;
        repeat (12) @(negedge clock_i);
    endtask
    task automatic nest();
        logic [4:0] exp[6] = '{5'h07, 5'h05, 5'h04, 5'h09, 5'h02, 5'h06};
        logic [31:0] m[3] = '{32'h0000_0080, 32'h0000_0264, 32'h0000_0010};
        offers.delete();
        foreach (m[i])
        begin
            @(posedge clock_i);
            req <= req | m[i];
            repeat (12) @(negedge clock_i);
        end
        repeat (5) pop();
        chk(offers.size() == 6, "offer count");
        foreach (exp[i]) chk(offers[i] === exp[i], "nesting order");
        pop();
        fin(1'b0);
    endtask
    task automatic wait_wake();
        int n;
        for (int i = 1; i < 3; i++)
        begin
            @(posedge clock_i);
            mode <= i[2:0];
            repeat (4) @(negedge clock_i);
            @(posedge clock_i);
            req[12] <= 1'b1;
            wait_sig(1, n);
            chk(n < 16, "no wake from wait");
            chk(low_voltage_detector === (i == 1), "detector enable");
            wait_sig(3, n);
            fin(1'b1);
        end
    endtask
    task automatic wake_src(input int s, input logic q, input logic [2:0] m, input logic e);
        int n;
        @(posedge clock_i);
        {mode, qual[s]} <= {m, q};
        repeat (4) @(negedge clock_i);
        @(posedge clock_i);
        evt[s] <= 1'b1;
        @(posedge clock_i);
        evt[s] <= 1'b0;
        wait_sig(2, n);
        chk((n < 40) === e, "wake source response");
        if (e)
        begin
            wait_sig(1, n);
            chk(n < 40, "no core wake after restart");
        end
        fin(1'b0);
    endtask
    task automatic stop_irq();
        int n;
        @(posedge clock_i);
        {mode, qual[3]} <= {3'h3, 1'b1};
        repeat (6) @(negedge clock_i);
        @(posedge clock_i);
        {req[11], evt[3]} <= 2'b11;
        @(posedge clock_i);
        evt[3] <= 1'b0;
        wait_sig(1, n);
        chk(pend[11] === 1'b1, "waking vector not pending");
        chk(valid === 1'b0, "offer while stopped");
        @(posedge clock_i);
        mode <= 3'h0;
        wait_sig(0, n);
        chk(id === 5'h0b, "waking vector not handled");
        wait_sig(3, n);
        fin(1'b1);
    endtask
    task reset_chk();
        chk(pend === 32'h0 && valid === 1'b0 && rreq === 1'b0, "reset outputs");
        chk(low_voltage_detector === 1'b1, "detector off after reset");
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clock_i)
        if (valid === 1'b1 && ack === 1'b1)
            offers.push_back(id);
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    initial
    begin
        repeat (30000) @(posedge clock_i);
        bad_count++;
        summarize();
    end
    initial
    begin
        {resetn_i, req, en, done, mode, evt, qual} = {1'b0, 32'h0, 32'hffff_ffff, 1'b0,
            3'h0, 10'h0, 10'h0};
        {ack_dly, stb_dly, bad_count, num_checks} = {4'h0, 4'h2, 32'sd0, 32'sd0};
        for (int i = 0; i < 32; i++)
            prio[2*i +: 2] = i[1:0];
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        reset_chk();
        basic();
        ack_dly <= 4'h3;
        nest();
        wait_wake();
        for (int s = 0; s < 10; s++)
            wake_src(s, 1'b1, (s % 2) ? 3'h4 : 3'h3, 1'b1);
        stb_dly <= 4'h6;
        for (int s = 3; s < 10; s++)
            wake_src(s, 1'b0, 3'h3, 1'b0);
        wake_src(1, 1'b0, 3'h4, 1'b0);
        wake_src(3, 1'b1, 3'h0, 1'b0);
        stop_irq();
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(negedge clock_i);
        reset_chk();
        summarize();
    end
endmodule
